// file: rtl/lrp_lamps.sv
`timescale 1ns/100ps
// Operation
// (RL1) Two lamp modes come from the mode strap and a third is selected only by configuration input.
// (RL2) Each lamp's active level follows the strap level seen on that pin at reset.
// (RL3) In mode one the link lamp is on exactly while the link is good.
// (RL4) In modes two and three the link lamp is on with link and blinks during tx or rx activity.
// (RL5) The rate lamp is on at 100 Mb/s and off at 10 Mb/s in every mode.
// (RL6) In mode one the third lamp shows tx or rx activity.
// (RL7) In mode two the third lamp shows collisions.
// (RL8) In mode three the third lamp may be set to show full duplex instead of collision.
// (RL9) The reset input must be held low at least 1 us, after which a full reset runs.
// (RL10) Pin reset returns all configuration state to its defaults.
// (RL11) Pin reset re-captures every strap instead of keeping old values.
// (RL12) By default the shared pin is an active-low power-down input.
// (RL13) When set for interrupts the shared pin is open drain and pulled low on an interrupt.
// (RL14) The host must configure interrupt use before the shared pin acts as an interrupt output.
// (RL15) Strap pins are sampled during reset and the captured values select modes afterwards; the code samples them on the fourth clock after reset release.
// (RL16) Activity blinking uses a fixed rate slow enough to see.
// (RL17) Each port has its own independent lamp, power-down and interrupt logic.
module lrp_lamps
  import lrp_pkg::*;
#(
  parameter int BLINK_HALF = BLINK_HALF_CYCLES
) (
  // clock and reset
  input  wire logic                 I_SYS_CLK,
  input  wire logic                 I_ARST_N,
  // strap levels seen on lamp pins, per port {act, rate, link}
  input  wire logic [2:0]           I_STRAP_PORT_A,
  input  wire logic [2:0]           I_STRAP_PORT_B,
  input  wire logic [NUM_PORTS-1:0] I_MODE_STRAP,
  // configuration
  input  wire logic [NUM_PORTS-1:0] I_MODE_THREE_EN,
  input  wire logic [NUM_PORTS-1:0] I_DUPLEX_SHOW_EN,
  input  wire logic [NUM_PORTS-1:0] I_IRQ_PIN_EN,
  // port status
  input  wire logic [NUM_PORTS-1:0] I_LINK_GOOD,
  input  wire logic [NUM_PORTS-1:0] I_SPEED_100,
  input  wire logic [NUM_PORTS-1:0] I_TX_ACTIVE,
  input  wire logic [NUM_PORTS-1:0] I_RX_ACTIVE,
  input  wire logic [NUM_PORTS-1:0] I_COLLISION,
  input  wire logic [NUM_PORTS-1:0] I_FULL_DUPLEX,
  input  wire logic [NUM_PORTS-1:0] I_IRQ_PENDING,
  // shared power-down / interrupt pins
  input  wire logic                 I_SLEEP_OR_IRQ_PIN_PORT_A,
  input  wire logic                 I_SLEEP_OR_IRQ_PIN_PORT_B,
  output logic                      O_SLEEP_OR_IRQ_PIN_PORT_A,
  output logic                      O_SLEEP_OR_IRQ_OE_PORT_A,
  output logic                      O_SLEEP_OR_IRQ_PIN_PORT_B,
  output logic                      O_SLEEP_OR_IRQ_OE_PORT_B,
  output logic [NUM_PORTS-1:0]      O_POWER_DOWN,
  // lamps
  output logic                      O_LINK_LAMP_PORT_A,
  output logic                      O_LINK_LAMP_PORT_B,
  output logic                      O_RATE_LAMP_PORT_A,
  output logic                      O_RATE_LAMP_PORT_B,
  output logic                      O_ACTIVITY_COLLISION_LAMP_PORT_A,
  output logic                      O_ACTIVITY_COLLISION_LAMP_PORT_B,
  output logic [NUM_PORTS-1:0]      O_STRAPS_VALID
);
  // strap capture after reset release
  logic [3:0]           cap_cnt;
  logic [3:0]           next_cap_cnt;
  logic                 captured;
  logic                 next_captured;
  logic [2:0]           pol_q     [NUM_PORTS];
  logic [2:0]           next_pol  [NUM_PORTS];
  logic [NUM_PORTS-1:0] mstrap;
  logic [NUM_PORTS-1:0] next_mstrap;
  logic [2:0]           strap_in  [NUM_PORTS];
  logic                 blink;

  assign strap_in[0] = I_STRAP_PORT_A;
  assign strap_in[1] = I_STRAP_PORT_B;

  lrp_blink #(
    .HALF_CYCLES (BLINK_HALF)
  ) u_blink (
    .clk    (I_SYS_CLK),
    .arst_n (I_ARST_N),
    .phase  (blink) // [RL16]
  );

  always_comb begin
    next_cap_cnt  = cap_cnt;
    next_captured = captured;
    next_mstrap   = mstrap;
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_pol[p] = pol_q[p];
    end
    if (!captured) begin
      next_cap_cnt = cap_cnt + 4'h1;
      if (cap_cnt == 4'(STRAP_DELAY_CYCLES - 1)) begin
        next_captured = 1'b1; // [RL11] [RL15]
        next_mstrap   = I_MODE_STRAP;
        for (int p = 0; p < NUM_PORTS; p++) begin
          next_pol[p] = strap_in[p]; // [RL2]
        end
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin // [RL9] [RL10]
      cap_cnt  <= 4'h0;
      captured <= 1'b0;
      mstrap   <= '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        pol_q[p] <= 3'h0;
      end
    end else begin
      cap_cnt  <= next_cap_cnt;
      captured <= next_captured;
      mstrap   <= next_mstrap;
      for (int p = 0; p < NUM_PORTS; p++) begin
        pol_q[p] <= next_pol[p];
      end
    end
  end

  // per-port lamp and pin logic
  logic [2:0]           lamp      [NUM_PORTS];
  logic [2:0]           next_lamp [NUM_PORTS];
  logic [NUM_PORTS-1:0] pin_oe;
  logic [NUM_PORTS-1:0] next_pin_oe;
  logic [NUM_PORTS-1:0] pdn;
  logic [NUM_PORTS-1:0] next_pdn;
  logic [NUM_PORTS-1:0] pin_in;

  assign pin_in = {I_SLEEP_OR_IRQ_PIN_PORT_B, I_SLEEP_OR_IRQ_PIN_PORT_A};

  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port // [RL17]
      lrp_mode_t mode;
      logic      act;
      logic      link_on;
      logic      third_on;

      always_comb begin
        act = I_TX_ACTIVE[p] | I_RX_ACTIVE[p];
        if (I_MODE_THREE_EN[p]) begin
          mode = LRP_MODE_THREE; // [RL1]
        end else if (mstrap[p]) begin
          mode = LRP_MODE_TWO;
        end else begin
          mode = LRP_MODE_ONE;
        end
        link_on  = 1'b0;
        third_on = 1'b0;
        case (mode)
          LRP_MODE_ONE: begin
            link_on  = I_LINK_GOOD[p]; // [RL3]
            third_on = act; // [RL6]
          end
          LRP_MODE_TWO: begin
            link_on  = I_LINK_GOOD[p] & ~(act & blink); // [RL4]
            third_on = I_COLLISION[p]; // [RL7]
          end
          default: begin
            link_on  = I_LINK_GOOD[p] & ~(act & blink); // [RL4]
            third_on = I_DUPLEX_SHOW_EN[p] ? I_FULL_DUPLEX[p] : I_COLLISION[p]; // [RL8]
          end
        endcase
        // a pin strapped low idles low, so its lamp is lit high
        next_lamp[p][STRAP_LINK_BIT] = link_on ^ pol_q[p][STRAP_LINK_BIT]; // [RL2]
        next_lamp[p][STRAP_RATE_BIT] = I_SPEED_100[p] ^ pol_q[p][STRAP_RATE_BIT]; // [RL5]
        next_lamp[p][STRAP_ACT_BIT]  = third_on ^ pol_q[p][STRAP_ACT_BIT];
        // lamp pins held low until straps are captured
        if (!captured) begin
          next_lamp[p] = pol_q[p];
        end
      end
    end
  endgenerate

  // shared pin: power-down input unless interrupt use is enabled
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_pin_oe[p] = I_IRQ_PIN_EN[p] & I_IRQ_PENDING[p]; // [RL13] [RL14]
      next_pdn[p]    = ~I_IRQ_PIN_EN[p] & ~pin_in[p]; // [RL12]
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        lamp[p] <= 3'h0;
      end
      pin_oe <= '0;
      pdn    <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        lamp[p] <= next_lamp[p];
      end
      pin_oe <= next_pin_oe;
      pdn    <= next_pdn;
    end
  end

  logic [NUM_PORTS-1:0] valid_q;

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      valid_q <= '0;
    end else begin
      valid_q <= {NUM_PORTS{captured}};
    end
  end

  assign O_LINK_LAMP_PORT_A               = lamp[0][STRAP_LINK_BIT];
  assign O_RATE_LAMP_PORT_A               = lamp[0][STRAP_RATE_BIT];
  assign O_ACTIVITY_COLLISION_LAMP_PORT_A = lamp[0][STRAP_ACT_BIT];
  assign O_LINK_LAMP_PORT_B               = lamp[1][STRAP_LINK_BIT];
  assign O_RATE_LAMP_PORT_B               = lamp[1][STRAP_RATE_BIT];
  assign O_ACTIVITY_COLLISION_LAMP_PORT_B = lamp[1][STRAP_ACT_BIT];
  // open drain: drive value is always low
  assign O_SLEEP_OR_IRQ_PIN_PORT_A        = 1'b0;
  assign O_SLEEP_OR_IRQ_PIN_PORT_B        = 1'b0;
  assign O_SLEEP_OR_IRQ_OE_PORT_A         = pin_oe[0];
  assign O_SLEEP_OR_IRQ_OE_PORT_B         = pin_oe[1];
  assign O_POWER_DOWN                     = pdn;
  assign O_STRAPS_VALID                   = valid_q;
endmodule : lrp_lamps

// file: rtl/lrp_pkg.sv
package lrp_pkg;
  localparam int NUM_PORTS = 2;
  // lamp modes
  typedef enum logic [1:0] {
    LRP_MODE_ONE,
    LRP_MODE_TWO,
    LRP_MODE_THREE
  } lrp_mode_t;
  // strap capture timing
  localparam real CLK_PERIOD_NS      = 10.0;
  localparam real RESET_MIN_US       = 1.0;
  localparam int  RESET_MIN_CYCLES   = int'((RESET_MIN_US * 1000.0 + CLK_PERIOD_NS - 1.0) / CLK_PERIOD_NS);
  localparam int  STRAP_DELAY_CYCLES = 4;
  // blink rate
  localparam real BLINK_HALF_MS      = 50.0;
  localparam int  BLINK_HALF_CYCLES  = int'(BLINK_HALF_MS * 1000000.0 / CLK_PERIOD_NS);
  localparam int  BLINK_CNT_W        = 23;
  // strap bit positions per port
  localparam int  STRAP_LINK_BIT     = 0;
  localparam int  STRAP_RATE_BIT     = 1;
  localparam int  STRAP_ACT_BIT      = 2;
endpackage : lrp_pkg

// file: rtl/lrp_blink.sv
`timescale 1ns/100ps
module lrp_blink
  import lrp_pkg::*;
#(
  parameter int HALF_CYCLES = BLINK_HALF_CYCLES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  output logic      phase
);
  logic [BLINK_CNT_W-1:0] cnt;
  logic [BLINK_CNT_W-1:0] next_cnt;
  logic                   next_phase;

  always_comb begin
    next_cnt   = cnt + {{(BLINK_CNT_W-1){1'b0}}, 1'b1};
    next_phase = phase;
    if (cnt >= BLINK_CNT_W'(HALF_CYCLES - 1)) begin
      next_cnt   = '0;
      next_phase = ~phase;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt   <= '0;
      phase <= 1'b0;
    end else begin
      cnt   <= next_cnt;
      phase <= next_phase;
    end
  end
endmodule : lrp_blink

// file: tb/lrp_lamps_sva.sv
`timescale 1ns/100ps
module lrp_lamps_sva (
  // clock and reset
  input wire logic       I_SYS_CLK,
  input wire logic       I_ARST_N,
  // straps and config
  input wire logic [2:0] I_STRAP_PORT_A,
  input wire logic [2:0] I_STRAP_PORT_B,
  input wire logic [1:0] I_MODE_STRAP,
  input wire logic [1:0] I_MODE_THREE_EN,
  input wire logic [1:0] I_DUPLEX_SHOW_EN,
  input wire logic [1:0] I_IRQ_PIN_EN,
  // status
  input wire logic [1:0] I_LINK_GOOD,
  input wire logic [1:0] I_SPEED_100,
  input wire logic [1:0] I_TX_ACTIVE,
  input wire logic [1:0] I_RX_ACTIVE,
  input wire logic [1:0] I_COLLISION,
  input wire logic [1:0] I_FULL_DUPLEX,
  input wire logic [1:0] I_IRQ_PENDING,
  input wire logic       I_SLEEP_OR_IRQ_PIN_PORT_A,
  // outputs
  input wire logic       O_SLEEP_OR_IRQ_PIN_PORT_A,
  input wire logic       O_SLEEP_OR_IRQ_OE_PORT_A,
  input wire logic [1:0] O_POWER_DOWN,
  input wire logic       O_LINK_LAMP_PORT_A,
  input wire logic       O_RATE_LAMP_PORT_A,
  input wire logic       O_RATE_LAMP_PORT_B,
  input wire logic       O_ACTIVITY_COLLISION_LAMP_PORT_A,
  input wire logic [1:0] O_STRAPS_VALID
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);
  wire       v   = O_STRAPS_VALID[0];
  wire       m1  = !I_MODE_THREE_EN[0] && !I_MODE_STRAP[0];
  wire       m2  = !I_MODE_THREE_EN[0] && I_MODE_STRAP[0];
  wire       d3  = I_MODE_THREE_EN[0] && I_DUPLEX_SHOW_EN[0];
  wire       act = I_TX_ACTIVE[0] || I_RX_ACTIVE[0];
  wire       b23 = v && !m1 && I_LINK_GOOD[0] && act;
  wire       irq = I_IRQ_PIN_EN[0] && I_IRQ_PENDING[0];
  wire       sl  = !I_IRQ_PIN_EN[0] && !I_SLEEP_OR_IRQ_PIN_PORT_A;
  wire [2:0] s   = I_STRAP_PORT_A;
  wire       ac  = O_ACTIVITY_COLLISION_LAMP_PORT_A;
  wire       lk  = O_LINK_LAMP_PORT_A;
  sequence s_busy; b23[*8]; endsequence
  sequence s_capture; !v[*4] ##[1:2] v; endsequence
  property p_rate; v |-> O_RATE_LAMP_PORT_A == ($past(I_SPEED_100[0]) ^ s[1]); endproperty
  a_rate: assert property (p_rate) else $error("rate lamp A wrong");
  property p_link1; v && $past(m1) |-> lk == ($past(I_LINK_GOOD[0]) ^ s[0]); endproperty
  a_link1: assert property (p_link1) else $error("link lamp A wrong");
  property p_act1; v && $past(m1) |-> ac == ($past(act) ^ s[2]); endproperty
  a_act1: assert property (p_act1) else $error("activity lamp A wrong");
  property p_col2; v && $past(m2) |-> ac == ($past(I_COLLISION[0]) ^ s[2]); endproperty
  a_col2: assert property (p_col2) else $error("collision lamp A wrong");
  property p_dup3; v && $past(d3) |-> ac == ($past(I_FULL_DUPLEX[0]) ^ s[2]); endproperty
  a_dup3: assert property (p_dup3) else $error("duplex lamp A wrong");
  property p_blink; s_busy |-> !(lk == $past(lk, 3) && lk == $past(lk, 6)); endproperty
  a_blink: assert property (p_blink) else $error("link lamp A not blinking");
  property p_irq; v |-> O_SLEEP_OR_IRQ_OE_PORT_A == $past(irq) && !O_SLEEP_OR_IRQ_PIN_PORT_A; endproperty
  a_irq: assert property (p_irq) else $error("irq drive A wrong");
  property p_pd; v |-> O_POWER_DOWN[0] == $past(sl); endproperty
  a_pd: assert property (p_pd) else $error("power down A wrong");
  property p_portb; O_STRAPS_VALID[1] |-> O_RATE_LAMP_PORT_B == ($past(I_SPEED_100[1]) ^ I_STRAP_PORT_B[1]); endproperty
  a_portb: assert property (p_portb) else $error("rate lamp B wrong");
  property p_cap; $rose(I_ARST_N) |-> s_capture; endproperty
  a_cap: assert property (p_cap) else $error("strap capture late");
endmodule : lrp_lamps_sva
bind lrp_lamps lrp_lamps_sva u_sva (.*);

// file: tb/lrp_host.sv
`timescale 1ns/100ps
module lrp_host (
  // pin pulls
  input  wire logic i_oe,
  input  wire logic i_sleep,
  // resolved wire
  output logic      o_pin
);
  // weak pull-up unless pulled low
  assign o_pin = !(i_oe || i_sleep);
endmodule : lrp_host

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic        I_SYS_CLK = 1'b0, I_ARST_N = 1'b0;
  logic [2:0]  I_STRAP_PORT_A = 3'h0, I_STRAP_PORT_B = 3'h7;
  logic [1:0]  I_MODE_STRAP = 2'h2, I_MODE_THREE_EN = 2'h0, I_DUPLEX_SHOW_EN = 2'h0, I_IRQ_PIN_EN = 2'h0;
  logic [1:0]  I_LINK_GOOD = 2'h0, I_SPEED_100 = 2'h0, I_TX_ACTIVE = 2'h0, I_RX_ACTIVE = 2'h0;
  logic [1:0]  I_COLLISION = 2'h0, I_FULL_DUPLEX = 2'h0, I_IRQ_PENDING = 2'h0, sleep = 2'h0, seen;
  logic        I_SLEEP_OR_IRQ_PIN_PORT_A, I_SLEEP_OR_IRQ_PIN_PORT_B, O_SLEEP_OR_IRQ_PIN_PORT_A;
  logic        O_SLEEP_OR_IRQ_OE_PORT_A, O_SLEEP_OR_IRQ_PIN_PORT_B, O_SLEEP_OR_IRQ_OE_PORT_B;
  logic        O_LINK_LAMP_PORT_A, O_LINK_LAMP_PORT_B, O_RATE_LAMP_PORT_A, O_RATE_LAMP_PORT_B;
  logic        O_ACTIVITY_COLLISION_LAMP_PORT_A, O_ACTIVITY_COLLISION_LAMP_PORT_B;
  logic [1:0]  O_POWER_DOWN, O_STRAPS_VALID;
  int          failures = 0, tests_run = 0;
  // {m3,dup,link,spd,tx,col,fdx, lamps A on-level, lamps B pin level}
  logic [12:0] rows [6] = '{13'h0007, 13'h061c, 13'h01a3, 13'h1c6a, 13'h12f1, 13'h1987};
  logic [12:0] r;
  lrp_lamps #(.BLINK_HALF(4)) dut (.*);
  lrp_host host_a (.i_oe(O_SLEEP_OR_IRQ_OE_PORT_A), .i_sleep(sleep[0]), .o_pin(I_SLEEP_OR_IRQ_PIN_PORT_A));
  lrp_host host_b (.i_oe(O_SLEEP_OR_IRQ_OE_PORT_B), .i_sleep(sleep[1]), .o_pin(I_SLEEP_OR_IRQ_PIN_PORT_B));
  always #5 I_SYS_CLK = ~I_SYS_CLK;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  initial begin
    #20us;
    failures++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge I_SYS_CLK);
    I_ARST_N <= 1'b1;
    repeat (8) @(posedge I_SYS_CLK);
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge I_SYS_CLK);
      {I_MODE_THREE_EN, I_DUPLEX_SHOW_EN} <= {{2{r[12]}}, {2{r[11]}}};
      {I_LINK_GOOD, I_SPEED_100, I_TX_ACTIVE} <= {{2{r[10]}}, {2{r[9]}}, {2{r[8]}}};
      {I_COLLISION, I_FULL_DUPLEX} <= {{2{r[7]}}, {2{r[6]}}};
      repeat (2) @(posedge I_SYS_CLK);
      #1 chk({O_ACTIVITY_COLLISION_LAMP_PORT_A, O_RATE_LAMP_PORT_A, O_LINK_LAMP_PORT_A,
              O_ACTIVITY_COLLISION_LAMP_PORT_B, O_RATE_LAMP_PORT_B, O_LINK_LAMP_PORT_B}, r[5:0]);
    end
    $display("lamp table done");
    @(posedge I_SYS_CLK);
    {I_MODE_THREE_EN, I_LINK_GOOD, I_RX_ACTIVE, I_TX_ACTIVE} <= {2'h1, 2'h3, 2'h3, 2'h0};
    seen = 2'h0;
    repeat (14) begin
      @(posedge I_SYS_CLK);
      #1 seen = seen | {~O_LINK_LAMP_PORT_A, O_LINK_LAMP_PORT_A};
    end
    chk(seen, 2'h3);
    $display("blink done");
    @(posedge I_SYS_CLK);
    {I_LINK_GOOD, I_RX_ACTIVE, sleep} <= {2'h0, 2'h0, 2'h1};
    repeat (3) @(posedge I_SYS_CLK);
    #1 chk({O_POWER_DOWN, O_SLEEP_OR_IRQ_OE_PORT_A}, 8'h02);
    @(posedge I_SYS_CLK);
    {sleep, I_IRQ_PIN_EN, I_IRQ_PENDING} <= {2'h0, 2'h3, 2'h2};
    repeat (3) @(posedge I_SYS_CLK);
    #1 chk({O_POWER_DOWN, O_SLEEP_OR_IRQ_OE_PORT_A, O_SLEEP_OR_IRQ_OE_PORT_B, I_SLEEP_OR_IRQ_PIN_PORT_B,
            O_SLEEP_OR_IRQ_PIN_PORT_B}, 8'h04);
    $display("pin modes done");
    @(posedge I_SYS_CLK);
    {I_ARST_N, I_IRQ_PIN_EN, I_IRQ_PENDING, I_MODE_THREE_EN} <= {1'b0, 6'h0};
    I_COLLISION <= 2'h0;
    {I_STRAP_PORT_A, I_MODE_STRAP} <= {3'h7, 2'h1};
    @(posedge I_SYS_CLK);
    #1 chk({O_STRAPS_VALID, O_LINK_LAMP_PORT_A, O_RATE_LAMP_PORT_A, O_POWER_DOWN}, 8'h00);
    repeat (100) @(posedge I_SYS_CLK);
    I_ARST_N <= 1'b1;
    repeat (8) @(posedge I_SYS_CLK);
    #1 chk({O_STRAPS_VALID[0], O_ACTIVITY_COLLISION_LAMP_PORT_A, O_RATE_LAMP_PORT_A, O_LINK_LAMP_PORT_A}, 8'h0f);
    @(posedge I_SYS_CLK);
    {I_SPEED_100, I_COLLISION} <= {2'h1, 2'h3};
    repeat (2) @(posedge I_SYS_CLK);
    #1 chk({O_RATE_LAMP_PORT_A, O_ACTIVITY_COLLISION_LAMP_PORT_A,
            O_ACTIVITY_COLLISION_LAMP_PORT_B}, 8'h01);
    $display("reset done");
    test_done();
  end
endmodule : testbench
